// ---- include/eewr_pkg.sv ----
// Shared constants for the two-wire memory slave write front end.
package eewr_pkg;
  localparam logic [3:0] EEWR_TYPE_CODE = 4'hA;
  localparam logic [2:0] EEWR_SEL_CODE = 3'h0;
  localparam logic [7:0] EEWR_ERASED = 8'hFF;
  localparam int EEWR_PAGE_BYTES = 16;
  localparam int EEWR_PAGE_BITS = 4;
  localparam int EEWR_ARRAY_BYTES = 256;
  localparam int EEWR_CLK_MHZ = 100;
  localparam int EEWR_PROG_TIME_US = 5000;
  localparam int EEWR_PROG_CYCLES = EEWR_PROG_TIME_US * EEWR_CLK_MHZ;
  typedef enum logic [2:0] {
    EEWR_IDLE = 3'h0,
    EEWR_ADDR = 3'h1,
    EEWR_WORD = 3'h3,
    EEWR_DATA = 3'h2,
    EEWR_SKIP = 3'h6
  } eewr_state_t;
endpackage

// ---- design/eewr_timer.sv ----
// Self-timed programming cycle counter in the system clock domain.
`timescale 1ns/1ps
`default_nettype none
module eewr_timer #(
  parameter int CYCLES = 500000
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic start_in,
  output logic busy_out,
  output logic done_out
);
  localparam int CW = $clog2(CYCLES + 1);
  logic [CW-1:0] cnt_ff;
  logic busy_ff;
  logic done_ff;
  wire last = (cnt_ff == CW'(CYCLES - 1));
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_ff <= '0;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      done_ff <= busy_ff && last;
      if (start_in && !busy_ff) begin
        busy_ff <= 1'b1;
        cnt_ff <= '0;
      end else if (busy_ff) begin
        cnt_ff <= cnt_ff + CW'(1);
        if (last) begin
          busy_ff <= 1'b0;
        end
      end
    end
  end
  assign busy_out = busy_ff;
  assign done_out = done_ff;
  a_busy_length: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R21
    $rose(busy_ff) |-> busy_ff[*8])
    else $error("busy dropped too early");
endmodule
`default_nettype wire

// ---- design/eewr_slave.sv ----
// Two-wire slave write front end with page buffer, array and write timer.
//
// Function
// [R1] Reset puts the device in standby, ignoring the bus until START.
// [R2] Data line is only pulled low or released, never driven high.
// [R3] Sample data on clock rise, change outgoing data on clock fall.
// [R4] Master alone makes the clock; zero pulls low, one releases.
// [R5] Master starts only on idle bus; data stable while clock high.
// [R6] Data fall with clock high is START; data rise is STOP.
// [R7] Ignore everything until START; STOP ends any command.
// [R8] Respond only when the first seven bits are 1010 000.
// [R9] Eighth bit one means read, zero means write; a read address is never acknowledged.
// [R10] Ninth clock: transmitter releases; receiver pulls low to acknowledge.
// [R11] Acknowledge address, word address and data unless protected or busy.
// [R12] STOP after write launches programming; acknowledge nothing meanwhile.
// [R13] Accept up to sixteen data bytes into a page buffer.
// [R14] Page bits latched, low index wraps inside the page.
// [R15] All loaded bytes are committed in one programming cycle.
// [R16] Master may poll with repeated requests until acknowledged.
// [R17] Sample write protect at last clock fall before first data byte.
// [R18] Protect high declines the data byte and discards the write.
// [R19] Low or undriven protect input has no effect on writes.
// [R20] Array starts with every byte erased to all ones.
// [R21] Programming duration is a parameter; busy flag held throughout.
// [R22] Array size is a parameter of 128 or 256 bytes.
`timescale 1ns/1ps
`default_nettype none
module eewr_slave
  import eewr_pkg::*;
#(
  parameter int ARRAY_BYTES = eewr_pkg::EEWR_ARRAY_BYTES,
  parameter int PROG_CYCLES = eewr_pkg::EEWR_PROG_CYCLES
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic scl_clk_in,
  input wire logic sda_in,
  input wire logic wp_in,
  output logic sda_out,
  output logic sda_oe_out,
  output logic busy_out,
  output logic wr_reject_out
);
  import eewr_pkg::*;
  localparam int AW = $clog2(ARRAY_BYTES);

  // Link domain. START/STOP are detected with the data line as clock while the
  // serial clock is high, the usual trick for a slave with no oversampling.
  logic start_ff;
  logic stop_ff;
  logic busy_ff;
  logic busy_l1_ff;
  logic busy_l2_ff;
  always_ff @(negedge sda_in or posedge rst_in) begin
    if (rst_in) begin
      start_ff <= 1'b0;
    end else if (scl_clk_in) begin
      start_ff <= ~start_ff; // R6
    end
  end
  always_ff @(posedge sda_in or posedge rst_in) begin
    if (rst_in) begin
      stop_ff <= 1'b0;
    end else if (scl_clk_in) begin
      stop_ff <= ~stop_ff; // R6
    end
  end

  eewr_state_t state_ff;
  logic [3:0] bit_ff;
  logic [7:0] shift_ff;
  logic start_tog_ff;
  logic [AW-1:0] addr_ff;
  logic wp_ok_ff;
  logic ack_ff;
  logic [EEWR_PAGE_BYTES*8-1:0] page_ff;
  logic [EEWR_PAGE_BYTES-1:0] pvalid_ff;

  wire new_start = start_ff != start_tog_ff;
  wire [7:0] byte_in = {shift_ff[6:0], sda_in};
  wire ninth = bit_ff == 4'h8;
  wire [EEWR_PAGE_BITS-1:0] pidx = addr_ff[EEWR_PAGE_BITS-1:0];

  // Rising edge: shift data in and advance the byte state.
  always_ff @(posedge scl_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_ff <= EEWR_IDLE; // R1
      bit_ff <= 4'h0;
      shift_ff <= 8'h00;
      start_tog_ff <= 1'b0;
      addr_ff <= '0;
      pvalid_ff <= '0;
      page_ff <= '0;
      busy_l1_ff <= 1'b0;
      busy_l2_ff <= 1'b0;
    end else begin
      busy_l1_ff <= busy_ff;
      busy_l2_ff <= busy_l1_ff;
      if (new_start) begin
        start_tog_ff <= start_ff;
        state_ff <= EEWR_ADDR;
        bit_ff <= 4'h1;
        shift_ff <= {7'h00, sda_in}; // R3
        pvalid_ff <= '0;
      end else if (state_ff != EEWR_IDLE && state_ff != EEWR_SKIP) begin // R7
        bit_ff <= ninth ? 4'h0 : bit_ff + 4'h1;
        if (!ninth) begin
          shift_ff <= byte_in; // R3
        end
        if (bit_ff == 4'h7) begin
          case (state_ff)
            EEWR_ADDR: begin
              if (byte_in[7:1] != {EEWR_TYPE_CODE, EEWR_SEL_CODE} || busy_l2_ff
                  || byte_in[0]) begin // R8 R9
                state_ff <= EEWR_SKIP; // R16
              end else begin
                state_ff <= EEWR_WORD;
              end
            end
            EEWR_WORD: begin
              addr_ff <= byte_in[AW-1:0]; // R22
              state_ff <= EEWR_DATA;
            end
            EEWR_DATA: begin
              if (!wp_ok_ff) begin
                state_ff <= EEWR_SKIP; // R18
              end else begin
                page_ff[pidx*8 +: 8] <= byte_in; // R13
                pvalid_ff[pidx] <= 1'b1;
                addr_ff <= {addr_ff[AW-1:EEWR_PAGE_BITS], pidx + 4'h1}; // R14
              end
            end
            default: state_ff <= EEWR_SKIP;
          endcase
        end
      end
    end
  end

  // Falling edge: drive acknowledge, sample write protect.
  always_ff @(negedge scl_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ack_ff <= 1'b0;
      wp_ok_ff <= 1'b1;
    end else begin
      ack_ff <= bit_ff == 4'h8 && state_ff != EEWR_IDLE && state_ff != EEWR_SKIP // R10 R11
          && !busy_l2_ff; // R12
      if (state_ff == EEWR_DATA && bit_ff == 4'h0 && pvalid_ff == '0) begin
        wp_ok_ff <= ~wp_in; // R17 R19
      end
    end
  end
  // Open drain: only ever pull low, released between acknowledges.
  assign sda_out = 1'b0; // R2
  assign sda_oe_out = ack_ff; // R12

  // The STOP toggle itself crosses through csync_ff. The page registers that qualify it
  // stand still after STOP, since the serial clock idles until the next START.
  // Limitation: a new START within about three system cycles of STOP would race the commit.

  // System domain: synchronise the STOP toggle, then program the array.
  logic [2:0] csync_ff;
  logic wp_s1_ff;
  logic wp_s2_ff;
  logic reject_ff;
  logic [7:0] mem [ARRAY_BYTES];
  logic [EEWR_PAGE_BYTES*8-1:0] page_s_ff;
  logic [EEWR_PAGE_BYTES-1:0] pv_s_ff;
  logic [AW-1:0] base_s_ff;
  logic tmr_busy;
  logic tmr_done;
  wire stop_edge = csync_ff[2] ^ csync_ff[1];
  wire commit = stop_edge && pvalid_ff != '0 && state_ff == EEWR_DATA; // R12 R15

  eewr_timer #(.CYCLES(PROG_CYCLES)) u_timer (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .start_in(commit),
    .busy_out(tmr_busy),
    .done_out(tmr_done)
  );

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      csync_ff <= 3'h0;
      busy_ff <= 1'b0;
      wp_s1_ff <= 1'b0;
      wp_s2_ff <= 1'b0;
      reject_ff <= 1'b0;
      page_s_ff <= '0;
      pv_s_ff <= '0;
      base_s_ff <= '0;
    end else begin
      csync_ff <= {csync_ff[1:0], stop_ff};
      wp_s1_ff <= ~wp_ok_ff;
      wp_s2_ff <= wp_s1_ff;
      reject_ff <= wp_s2_ff;
      busy_ff <= commit | tmr_busy; // R21
      if (commit) begin
        page_s_ff <= page_ff;
        pv_s_ff <= pvalid_ff;
        base_s_ff <= addr_ff;
      end
    end
  end

  // Array: erased at time zero (not by reset), all loaded bytes written at once when timer ends.
  // A plain clocked process, because the erase below is a second writer of the array.
  always @(posedge ref_clk_in) begin
    if (tmr_done) begin
      for (int i = 0; i < EEWR_PAGE_BYTES; i++) begin
        if (pv_s_ff[i]) begin
          mem[{base_s_ff[AW-1:EEWR_PAGE_BITS], 4'(i)}] <= page_s_ff[i*8 +: 8]; // R15
        end
      end
    end
  end
  initial begin
    for (int j = 0; j < ARRAY_BYTES; j++) begin
      mem[j] = EEWR_ERASED; // R20
    end
  end

  assign busy_out = busy_ff;
  assign wr_reject_out = reject_ff;

  a_oe_busy: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R12
    tmr_busy [*3] |-> !sda_oe_out)
    else $error("acknowledge during programming");
  a_skip_quiet: assert property (@(negedge scl_clk_in) disable iff (rst_in) // R7
    state_ff == EEWR_SKIP |=> !sda_oe_out)
    else $error("acknowledge while ignoring the bus");
  a_page_wrap: assert property (@(posedge scl_clk_in) disable iff (rst_in) // R14
    state_ff == EEWR_DATA && bit_ff == 4'h7 && wp_ok_ff && !new_start
    |=> addr_ff[AW-1:EEWR_PAGE_BITS] == $past(addr_ff[AW-1:EEWR_PAGE_BITS]))
    else $error("page bits moved during page load");
  a_done_idle: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R21
    tmr_done |-> !tmr_busy)
    else $error("timer done while still busy");
  a_commit_busy: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R21
    commit |=> busy_ff ##1 busy_ff)
    else $error("busy not raised on commit");
  a_out_low: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R2
    sda_oe_out |-> !sda_out)
    else $error("data driven high");
  a_wp_reject: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R18
    $rose(wp_s2_ff) |=> reject_ff)
    else $error("reject flag missed");
endmodule
`default_nettype wire

// ---- bench/eewr_master.sv ----
// Behavioural two-wire bus master that clocks the link only inside frames.
`timescale 1ns/1ps
`default_nettype none
module eewr_master (
  input wire logic ref_clk_in,
  input wire logic sda_in,
  output var logic scl_out,
  output var logic sda_oe_out
);
  task automatic phase(input int n);
    repeat (n) @(posedge ref_clk_in);
  endtask
  task automatic start();
    sda_oe_out <= 1'b1;
    phase(4);
    scl_out <= 1'b0;
    phase(4);
  endtask
  task automatic stop();
    phase(1);
    sda_oe_out <= 1'b1;
    phase(3);
    scl_out <= 1'b1;
    phase(4);
    sda_oe_out <= 1'b0;
    phase(4);
  endtask
  // Data moves one cycle after the clock falls, so no edge looks like START or STOP.
  task automatic send(input logic [7:0] b, output logic ack);
    logic [8:0] sh;
    sh = {b, 1'b1};
    for (int i = 0; i < 9; i++) begin
      phase(1);
      sda_oe_out <= !sh[8];
      sh = sh << 1;
      phase(3);
      scl_out <= 1'b1;
      phase(4);
      ack = !sda_in;
      scl_out <= 1'b0;
    end
  endtask
  initial begin
    scl_out = 1'b1;
    sda_oe_out = 1'b0;
  end
endmodule
`default_nettype wire

// ---- bench/tb_eewr_slave.sv ----
// Self-checking bench for the two-wire memory write front end.
`timescale 1ns/1ps
`default_nettype none
module tb_eewr_slave;
  import eewr_pkg::*;
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic wp_in = 1'b0;
  logic scl, m_oe, s_oe, s_out, busy, rej, ack;
  logic [31:0] seed = 32'h00011F9B;
  logic [31:0] r;
  bit mdl_busy = 1'b0;
  logic [7:0] mdl_mem [256] = '{default: EEWR_ERASED};
  int n_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  // The line is pulled up, so it reads high whenever nobody pulls it low.
  wire logic sda = m_oe ? 1'b0 : (s_oe ? s_out : 1'b1);
  eewr_master eewr_master_inst (.ref_clk_in(ref_clk_in), .sda_in(sda), .scl_out(scl),
    .sda_oe_out(m_oe));
  eewr_slave #(.PROG_CYCLES(400)) eewr_slave_inst (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .scl_clk_in(scl), .sda_in(sda), .wp_in(wp_in), .sda_out(s_out), .sda_oe_out(s_oe),
    .busy_out(busy), .wr_reject_out(rej));
  initial begin
    forever #5 ref_clk_in = ~ref_clk_in;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic print_verdict();
    if (n_errors == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic check(input string what, input logic exp, input logic seen);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, seen);
    end
  endtask
  task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] seen);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic check_mem();
    for (int k = 0; k < 256; k++) begin
      check8("array byte", mdl_mem[k], eewr_slave_inst.mem[k]);
    end
  endtask
  task automatic write(input logic [7:0] adr, input int n, input logic wp);
    bit go;
    logic [7:0] wa;
    wp_in <= wp;
    eewr_master_inst.start();
    eewr_master_inst.send(adr, ack);
    go = (adr == {EEWR_TYPE_CODE, EEWR_SEL_CODE, 1'b0}) && !mdl_busy;
    check("address ack", go, ack);
    if (go) begin
      r = rnd();
      eewr_master_inst.send(r[7:0], ack);
      check("word ack", 1'b1, ack);
      wa = r[7:0];
      for (int i = 0; i < n; i++) begin
        r = rnd();
        eewr_master_inst.send(r[7:0], ack);
        check("data ack", !wp, ack);
        if (!wp)
          mdl_mem[{wa[7:4], wa[3:0] + 4'(i)}] = r[7:0];
        if (wp)
          break;
      end
      mdl_busy = !wp && n > 0;
    end
    eewr_master_inst.stop();
    repeat (10) @(posedge ref_clk_in);
    check("busy", mdl_busy, busy);
    if (go)
      check("reject", wp, rej);
  endtask
  // Polls until the slave answers again; the first poll lands inside programming.
  task automatic poll();
    int k;
    k = 0;
    ack = 1'b0;
    while (!ack && k < 12) begin
      eewr_master_inst.start();
      eewr_master_inst.send(8'hA0, ack);
      eewr_master_inst.stop();
      if (k == 0)
        check("first poll", 1'b0, ack);
      k++;
    end
    check("poll ack", 1'b1, ack);
    check("busy end", 1'b0, busy);
    mdl_busy = 1'b0;
    check_mem();
  endtask
  always @(posedge ref_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      print_verdict();
    end
  end
  initial begin
    repeat (5) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    repeat (3) @(posedge ref_clk_in);
    check("busy after reset", 1'b0, busy);
    check("ack after reset", 1'b0, s_oe);
    check("reject after reset", 1'b0, rej);
    check_mem();
    write(8'hA0, 1, 1'b0);
    write(8'hA0, 2, 1'b0);
    poll();
    write(8'hA1, 1, 1'b0);
    write(8'hA2, 1, 1'b0);
    for (int j = 0; j < 4; j++) begin
      r = rnd();
      if (r[7:1] == 7'h50)
        r[2] = !r[2];
      write(r[7:0], 1, 1'b0);
    end
    write(8'hA0, 18, 1'b0);
    poll();
    write(8'hA0, 3, 1'b1);
    write(8'hA0, 1, 1'b0);
    poll();
    print_verdict();
  end
endmodule
`default_nettype wire
